// ===== design/ocl_fault_limit.sv
// Purpose: Input overcurrent threshold registers and fault delay control
// Assumes: Host accesses registers by command code with byte enables, one per cycle
// Notes:   Measured current arrives as a mantissa at the same exponent
//
// Behaviour
// [R1] Declare overcurrent when measured current exceeds programmed threshold.
// [R2] Threshold bits 15:11 read-only, return exponent; value is Y times 2^N.
// [R3] Returned exponent comes from exponent register bits 10:6.
// [R4] Threshold bits 10:8 read/write, hold mantissa high three bits.
// [R5] Threshold bits 7:0 read/write, hold mantissa low byte.
// [R6] Delay code selects delay before disabling and restart interval.
// [R7] Mantissa applied as a whole; never mixes old high with new low.
`timescale 1ns/1ns
module ocl_fault_limit
   import ocl_pkg::*;
#(
   parameter int MS_CYC = OCL_MS_CYC
)(
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  resetn,
   // Register access
   input  wire logic [15:0]           reg_addr,
   input  wire logic                  reg_wr,
   input  wire logic [1:0]            reg_be,
   input  wire logic [15:0]           reg_wdata,
   input  wire logic                  reg_rd,
   output logic      [15:0]           reg_rdata,
   output logic                       reg_rvalid,
   output logic                       reg_err,
   // Measured input current
   input  wire logic [OCL_MANT_W-1:0] iin_mant,
   input  wire logic                  iin_valid,
   // Fault outputs
   output logic                       oc_fault,
   output logic                       out_disable,
   output logic                       restart
);

   ////////////////////////////////////////////////////////////////////
   // Register storage

   logic [OCL_MANT_W-1:0] mant_r;      // Applied mantissa
   logic [7:0]            low_stage_r; // Low byte awaiting high byte
   logic                  low_pend_r;
   logic [15:0]           exp_reg_r;
   logic [OCL_DLY_W-1:0]  dly_code_r;

   wire sel_thresh = (reg_addr == OCL_ADDR_THRESH);
   wire sel_react  = (reg_addr == OCL_ADDR_REACT);
   wire sel_exp    = (reg_addr == OCL_ADDR_EXP);
   wire mapped     = sel_thresh || sel_react || sel_exp;
   wire wr_thresh  = reg_wr && sel_thresh;
   wire wr_exp     = reg_wr && sel_exp;
   wire wr_react   = reg_wr && sel_react && reg_be[0];

   wire [OCL_EXP_W-1:0] exp_n =
      exp_reg_r[OCL_EXP_LSB +: OCL_EXP_W];                 // see [R3]

   // Staged low byte wins over the applied one; commit and read both use it
   function automatic logic [7:0] pick_low(input logic       pend,
                                           input logic [7:0] staged,
                                           input logic [7:0] applied);
      return pend ? staged : applied;
   endfunction

   // Low byte of the next applied mantissa
   wire [7:0] low_next = reg_be[0] ? reg_wdata[7:0]
                       : pick_low(low_pend_r, low_stage_r, mant_r[7:0]);

   // A high-byte write commits; a lone low-byte write is only staged
   wire commit = wr_thresh && reg_be[1];                   // see [R7]
   wire [OCL_MANT_W-1:0] mant_nxt =
      {reg_wdata[10:8], low_next};                         // see [R4]

   // Read view of the threshold: exponent over applied high bits and the staged low byte if pending, else the applied one
   wire [7:0]  low_view   = pick_low(low_pend_r, low_stage_r, mant_r[7:0]);
   wire [15:0] thresh_rd  = {exp_n, mant_r[10:8], low_view}; // see [R2]

   wire [15:0] rd_mux = sel_thresh ? thresh_rd
                      : sel_react  ? {13'h0000, dly_code_r}
                      : sel_exp    ? exp_reg_r
                      :              16'h0000;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         mant_r      <= OCL_MANT_RST;
         low_stage_r <= 8'h00;
         low_pend_r  <= 1'b0;
      end else if (commit) begin
         mant_r     <= mant_nxt;                           // see [R7]
         low_pend_r <= 1'b0;
      end else if (wr_thresh && reg_be[0]) begin
         low_stage_r <= reg_wdata[7:0];                    // see [R5]
         low_pend_r  <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         exp_reg_r  <= OCL_EXP_RST;
         dly_code_r <= OCL_DLY_RST;
      end else begin
         if (wr_exp && reg_be[0])
            exp_reg_r[7:0] <= reg_wdata[7:0];
         if (wr_exp && reg_be[1])
            exp_reg_r[15:8] <= reg_wdata[15:8];
         if (wr_react)
            dly_code_r <= reg_wdata[2:0];                  // see [R6]
      end
   end

   // Read data registered; unmapped addresses read zero and flag error
   always_ff @(posedge clk) begin
      if (!resetn) begin
         reg_rdata  <= 16'h0000;
         reg_rvalid <= 1'b0;
         reg_err    <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         reg_err    <= (reg_rd || reg_wr) && !mapped;
         if (reg_rd)
            reg_rdata <= rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Threshold comparison

   // Both sides share exponent N, so comparing mantissas compares
   // Y x 2^N exactly without a wide shifter
   logic over_r;

   always_ff @(posedge clk) begin
      if (!resetn)
         over_r <= 1'b0;
      else if (iin_valid)
         over_r <= (iin_mant > mant_r);                    // see [R1]
   end

   assign oc_fault = over_r;                               // see [R1]

   ////////////////////////////////////////////////////////////////////
   // Millisecond tick divider

   // Free-running, so every delay carries up to one ms of phase slack
   logic [16:0] div_r;
   wire         ms_tick = (div_r == 17'(MS_CYC - 1));

   always_ff @(posedge clk) begin
      if (!resetn)
         div_r <= 17'h0_0000;
      else if (ms_tick)
         div_r <= 17'h0_0000;
      else
         div_r <= div_r + 17'h0_0001;
   end

   ////////////////////////////////////////////////////////////////////
   // Fault delay sequencing

   ocl_state_t state_r;
   ocl_state_t state_nxt;
   logic       tmr_start;
   logic [11:0] tmr_load;
   logic       tmr_done;

   // A fault still present at restart starts the delay over
   // Delay code is sampled when each delay starts
   wire [11:0] dly1 = OCL_DLY1_MS[dly_code_r];             // see [R6]
   wire [11:0] dly2 = OCL_DLY2_MS[dly_code_r];             // see [R6]

   always_comb begin
      state_nxt = state_r;
      tmr_start = 1'b0;
      tmr_load  = dly1;
      unique case (state_r)
         OCL_IDLE: begin
            if (over_r) begin
               state_nxt = OCL_WAIT;
               tmr_start = 1'b1;
            end
         end
         OCL_WAIT: begin
            // Fault gone before delay 1 ends: no shutdown
            if (!over_r)
               state_nxt = OCL_IDLE;
            else if (tmr_done) begin
               state_nxt = OCL_OFF;
               tmr_start = 1'b1;
               tmr_load  = dly2;
            end
         end
         OCL_OFF: begin
            if (tmr_done)
               state_nxt = OCL_IDLE;
         end
         default: state_nxt = OCL_IDLE;
      endcase
   end

   ocl_ms_timer u_timer (
      .clk     (clk),
      .resetn  (resetn),
      .start   (tmr_start),
      .load_ms (tmr_load),
      .ms_tick (ms_tick),
      .done    (tmr_done)
   );

   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_r     <= OCL_IDLE;
         out_disable <= 1'b0;
         restart     <= 1'b0;
      end else begin
         state_r     <= state_nxt;
         out_disable <= (state_nxt == OCL_OFF);            // see [R6]
         restart     <= (state_r == OCL_OFF) && tmr_done;  // see [R6]
      end
   end

endmodule // ocl_fault_limit

// ===== design/ocl_ms_timer.sv
// Purpose: Millisecond down-counter timing one fault delay
// Assumes: ms_tick is a one-cycle pulse once per millisecond
// Notes:   A start reloads the count even while a delay runs
`timescale 1ns/1ns
module ocl_ms_timer
   import ocl_pkg::*;
(
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                resetn,
   // Control
   input  wire logic                start,
   input  wire logic [OCL_MS_W-1:0] load_ms,
   input  wire logic                ms_tick,
   // Status
   output logic                     done
);

   logic [OCL_MS_W-1:0] cnt_r;
   logic                run_r;

   wire last_ms = run_r && ms_tick && (cnt_r == 12'h0001);

   always_ff @(posedge clk) begin
      if (!resetn) begin
         cnt_r <= 12'h0000;
         run_r <= 1'b0;
         done  <= 1'b0;
      end else begin
         done <= last_ms && !start;
         if (start) begin
            cnt_r <= load_ms;
            run_r <= 1'b1;
         end else if (run_r && ms_tick) begin
            cnt_r <= cnt_r - 12'h0001;
            run_r <= !last_ms;
         end
      end
   end

endmodule // ocl_ms_timer

// ===== design/ocl_pkg.sv
// Purpose: Shared constants for the input overcurrent threshold block
// Assumes: 100 MHz clock, byte-enabled register access by command code
// Notes:   Delay tables are in milliseconds, indexed by the 3-bit code
package ocl_pkg;

   // Command codes of the reachable registers
   localparam logic [15:0] OCL_ADDR_THRESH = 16'h005B;
   localparam logic [15:0] OCL_ADDR_REACT  = 16'h005C;
   localparam logic [15:0] OCL_ADDR_EXP    = 16'hFE39;

   // Field layout of the threshold, exponent and delay code registers
   localparam int OCL_MANT_W    = 11;
   localparam int OCL_EXP_W     = 5;
   localparam int OCL_EXP_LSB   = 6;   // Exponent sits in bits 10:6
   localparam int OCL_DLY_W     = 3;

   // Values after reset
   localparam logic [10:0] OCL_MANT_RST  = 11'h07FF;
   localparam logic [15:0] OCL_EXP_RST   = 16'h0000;
   localparam logic [2:0]  OCL_DLY_RST   = 3'h0;

   // Timing: one millisecond in clock cycles
   localparam int OCL_CLK_PERIOD_NS = 10;
   localparam int OCL_MS_NS         = 1_000_000;
   localparam int OCL_MS_CYC        = OCL_MS_NS / OCL_CLK_PERIOD_NS;
   localparam int OCL_MS_W          = 12;

   // Delay before disabling, and interval between restarts, in ms
   localparam logic [11:0] OCL_DLY1_MS [8] = '{
      12'h000A, 12'h0014, 12'h0028, 12'h0050,
      12'h00A0, 12'h0140, 12'h0280, 12'h0500};
   localparam logic [11:0] OCL_DLY2_MS [8] = '{
      12'h00FC, 12'h022E, 12'h039C, 12'h04EC,
      12'h063C, 12'h078C, 12'h08DC, 12'h0A2C};

   // Fault handling states
   typedef enum logic [1:0] {
      OCL_IDLE  = 2'b00,
      OCL_WAIT  = 2'b01,
      OCL_OFF   = 2'b10
   } ocl_state_t;

endpackage

// ===== tb/ocl_fault_limit_asserts.sv
// Purpose: Port checks for the overcurrent threshold block
// Assumes: Host never reads and writes in the same cycle
// Notes:   Exponent shadow follows host writes byte by byte
`timescale 1ns/1ns
module ocl_fault_limit_asserts
   import ocl_pkg::*;
(
   // Clock and reset
   input wire logic        clk,
   input wire logic        resetn,
   // Register access
   input wire logic [15:0] reg_addr,
   input wire logic        reg_wr,
   input wire logic [1:0]  reg_be,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic        reg_rvalid,
   input wire logic        reg_err,
   // Current and fault
   input wire logic [10:0] iin_mant,
   input wire logic        iin_valid,
   input wire logic        oc_fault,
   input wire logic        out_disable,
   input wire logic        restart
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   logic [4:0] exp_r;
   wire map_w = reg_addr == OCL_ADDR_THRESH || reg_addr == OCL_ADDR_REACT
      || reg_addr == OCL_ADDR_EXP;
   always_ff @(posedge clk) begin
      if (!resetn) exp_r <= 5'h00;
      else if (reg_wr && reg_addr == OCL_ADDR_EXP) begin
         if (reg_be[1]) exp_r[4:2] <= reg_wdata[10:8];
         if (reg_be[0]) exp_r[1:0] <= reg_wdata[7:6];
      end
   end
   read_answer_a: assert property (
      reg_rd && map_w |=> reg_rvalid) else $error("no read answer");
   unmapped_read_a: assert property (
      reg_rd && !map_w |=> reg_err && reg_rdata == 16'h0000)
      else $error("unmapped read");
   exp_mirror_a: assert property (
      reg_rd && reg_addr == OCL_ADDR_THRESH |=> reg_rdata[15:11] == exp_r)
      else $error("exponent field wrong");
   code_back_a: assert property (
      reg_wr && reg_be[0] && reg_addr == OCL_ADDR_REACT ##2
      reg_rd && reg_addr == OCL_ADDR_REACT
      |=> reg_rdata == {13'h0000, $past(reg_wdata[2:0], 3)})
      else $error("delay code readback");
   zero_no_fault_a: assert property (
      iin_valid && iin_mant == 11'h000 |=> !oc_fault)
      else $error("fault on zero current");
   hold_no_sample_a: assert property (
      !iin_valid |=> $stable(oc_fault))
      else $error("fault moved without sample");
   disable_cause_a: assert property (
      $rose(out_disable) |-> $past(oc_fault)) else $error("stray disable");
   restart_pulse_a: assert property (
      restart |=> !restart) else $error("restart too long");
   restart_off_a: assert property (
      restart |-> $past(out_disable)) else $error("restart while on");
endmodule // ocl_fault_limit_asserts
bind ocl_fault_limit ocl_fault_limit_asserts u_chk (.clk, .resetn,
   .reg_addr, .reg_wr, .reg_be, .reg_wdata, .reg_rd, .reg_rdata,
   .reg_rvalid, .reg_err, .iin_mant, .iin_valid, .oc_fault,
   .out_disable, .restart);

// ===== tb/ocl_fault_limit_tb.sv
// Purpose: Register and fault-delay tests of the threshold block
// Assumes: One millisecond shortened to 4 clock cycles
// Notes:   Delay windows allow one millisecond of tick slack
`timescale 1ns/1ns
module ocl_fault_limit_tb
   import ocl_pkg::*;
;
   logic clk, resetn, iin_valid, reg_wr, reg_rd, reg_rvalid, reg_err, e;
   logic oc_fault, out_disable, restart;
   logic [10:0] iin_mant;
   logic [15:0] reg_addr, reg_wdata, reg_rdata, d;
   logic [1:0]  reg_be;
   int fail_count, n_checks, n;
   localparam int MSC = 4;
   int d1 [8] = '{10, 20, 40, 80, 160, 320, 640, 1280};
   int d2 [8] = '{252, 558, 924, 1260, 1596, 1932, 2268, 2604};
   ocl_fault_limit #(.MS_CYC(MSC)) dut (.clk, .resetn, .reg_addr, .reg_wr,
      .reg_be, .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid, .reg_err,
      .iin_mant, .iin_valid, .oc_fault, .out_disable, .restart);
   ocl_host host (.clk, .reg_addr, .reg_wr, .reg_be, .reg_wdata, .reg_rd,
      .reg_rdata, .reg_rvalid, .reg_err);
   task automatic chk(input logic [15:0] g, input logic [15:0] x);
      n_checks++;
      if (g !== x) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic set_i(input logic [10:0] m);
      @(posedge clk);
      iin_mant <= m;
      repeat (3) @(posedge clk);
      #1;
   endtask
   // Counts cycles until disable (sel 0) or restart (sel 1) shows
   task automatic wait_ev(input logic sel, input int lim);
      n = 0;
      while ((sel ? restart : out_disable) !== 1'b1) begin
         @(posedge clk);
         #1;
         n++;
         if (n > lim) begin
            fail_count++;
            report_and_stop();
         end
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      resetn = 1'b0;
      iin_valid = 1'b1;
      iin_mant = 11'h000;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      host.rd(OCL_ADDR_THRESH, d, e);
      chk(d, 16'h07FF);
      host.rd(OCL_ADDR_REACT, d, e);
      chk(d, 16'h0000);
      host.wr(OCL_ADDR_EXP, 2'h3, 16'h0540);
      host.rd(OCL_ADDR_EXP, d, e);
      chk(d, 16'h0540);
      host.wr(OCL_ADDR_THRESH, 2'h3, 16'hFFFF);
      host.rd(OCL_ADDR_THRESH, d, e);
      chk(d, 16'hAFFF);
      host.wr(OCL_ADDR_THRESH, 2'h3, 16'h0123);
      host.rd(OCL_ADDR_THRESH, d, e);
      chk(d, 16'hA923);
      host.wr(OCL_ADDR_THRESH, 2'h1, 16'h0045);
      host.rd(OCL_ADDR_THRESH, d, e);
      chk(d, 16'hA945);
      host.wr(16'h0060, 2'h3, 16'h0000);
      host.rd(OCL_ADDR_THRESH, d, e);
      chk(d, 16'hA945);
      set_i(11'h124);
      chk(16'(oc_fault), 16'h0001);
      set_i(11'h123);
      chk(16'(oc_fault), 16'h0000);
      host.wr(OCL_ADDR_THRESH, 2'h2, 16'h0100);
      set_i(11'h144);
      chk(16'(oc_fault), 16'h0000);
      @(posedge clk);
      iin_valid <= 1'b0;
      set_i(11'h7FF);
      chk(16'(oc_fault), 16'h0000);
      @(posedge clk);
      iin_valid <= 1'b1;
      set_i(11'h146);
      chk(16'(oc_fault), 16'h0001);
      host.rd(16'h0060, d, e);
      chk({e, d[14:0]}, 16'h8000);
      set_i(11'h000);
      repeat (60) @(posedge clk);
      #1;
      chk(16'(out_disable), 16'h0000);
      for (int c = 0; c < 8; c++) begin
         set_i(11'h000);
         host.wr(OCL_ADDR_REACT, 2'h1, 16'(c));
         host.rd(OCL_ADDR_REACT, d, e);
         chk(d, 16'(c));
         set_i(11'h400);
         wait_ev(1'b0, 5200);
         chk(16'(n >= MSC * (d1[c] - 1) && n <= MSC * (d1[c] + 1)),
             16'h0001);
         wait_ev(1'b1, 10500);
         chk(16'(n >= MSC * (d2[c] - 1) && n <= MSC * (d2[c] + 1)),
             16'h0001);
         chk(16'(out_disable), 16'h0000);
      end
      report_and_stop();
   end
endmodule // ocl_fault_limit_tb

// ===== tb/ocl_host.sv
// Purpose: Host model driving command-code register accesses
// Assumes: One access at a time, strobes one cycle long
// Notes:   Released write data is inverted, not left showing
`timescale 1ns/1ns
module ocl_host (
   // Clock
   input  wire logic        clk,
   // Access
   output logic      [15:0] reg_addr,
   output logic             reg_wr,
   output logic      [1:0]  reg_be,
   output logic      [15:0] reg_wdata,
   output logic             reg_rd,
   // Answer
   input  wire logic [15:0] reg_rdata,
   input  wire logic        reg_rvalid,
   input  wire logic        reg_err
);
   initial begin
      reg_addr = 16'h0000;
      reg_be = 2'h0;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   task automatic wr(input logic [15:0] a, input logic [1:0] b,
                     input logic [15:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_be <= b;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~v;
   endtask
   task automatic rd(input logic [15:0] a, output logic [15:0] v,
                     output logic e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      v = (reg_rvalid || reg_err) ? reg_rdata : 16'hxxxx;
      e = reg_err;
   endtask
endmodule // ocl_host
